//--- inc/gpm_pkg.sv
// Purpose: Shared constants of the gigabit transceiver management register bank.
// Assumes: Five-bit register addresses and 16-bit register words.
// Notes:   Extended space holds eight words on page one.
package gpm_pkg;
  // Register offsets on the management port.
  localparam logic [4:0] OFF_GIG_CTL    = 5'h09;
  localparam logic [4:0] OFF_GIG_STAT   = 5'h0a;
  localparam logic [4:0] OFF_EXT_CTL    = 5'h0b;
  localparam logic [4:0] OFF_EXT_WDATA  = 5'h0c;
  localparam logic [4:0] OFF_EXT_RDATA  = 5'h0d;
  localparam logic [4:0] OFF_EXT_STAT   = 5'h0f;
  localparam logic [4:0] OFF_LOOP_LED   = 5'h11;
  localparam logic [4:0] OFF_CABLE_DIAG = 5'h12;
  localparam logic [4:0] OFF_PCS_LINK   = 5'h13;
  localparam logic [4:0] OFF_RXERR_CNT  = 5'h15;
  localparam logic [4:0] OFF_INT_CS     = 5'h1b;
  localparam logic [4:0] OFF_DEBUG_CTL  = 5'h1c;
  localparam logic [4:0] OFF_PHY_CTL    = 5'h1f;
  // Values after reset, fixed read values and the PHY control write mask.
  localparam logic [7:0]  RST_GIG_CTL_HI = 8'h02;
  localparam logic [15:0] RST_LOOP_LED   = 16'h02f0;
  localparam logic [15:0] RST_PHY_CTL    = 16'h0200;
  localparam logic [15:0] EXT_STAT_VALUE = 16'h3000;
  localparam logic [15:0] PHY_CTL_WMASK  = 16'hf380;
  localparam logic [15:0] RST_EXT_SKEW   = 16'h7777;
  // Field positions.
  localparam int GC_MANUAL_EN  = 12;
  localparam int GC_MANUAL_VAL = 11;
  localparam int GC_PORT_TYPE  = 10;
  localparam int GC_ADV_FULL   = 9;
  localparam int GC_ADV_HALF   = 8;
  localparam int EC_WRITE      = 15;
  localparam int EC_PAGE       = 8;
  localparam int LL_REMOTE_LB  = 8;
  localparam int LL_LED_TEST   = 3;
  localparam int CD_START      = 15;
  localparam int DC_MDI_SET    = 7;
  localparam int DC_SWAP_OFF   = 6;
  localparam int DC_PCS_LB     = 0;
  localparam int PC_INT_LEVEL  = 14;
  localparam int PC_JAB_EN     = 9;
  // Extended store geometry and strap settle count in cycles.
  localparam int EXT_DEPTH     = 8;
  localparam int EXT_BASE_IDX  = 4;
  localparam logic [1:0] STRAP_SETTLE = 2'd3;
endpackage

//--- inc/gpm_ext_if.sv
// Purpose: Carrier between the register bank and the extended register store.
// Assumes: One clock domain.
// Notes:   Read data is combinational from the store.
`timescale 1ns/1ns
interface gpm_ext_if;
  logic        wrEn;
  logic [8:0]  addr;
  logic [15:0] wrData;
  logic [15:0] rdData;
  modport bank  (output wrEn, output addr, output wrData, input rdData);
  modport store (input wrEn, input addr, input wrData, output rdData);
endinterface

//--- rtl/gpm_ext_store.sv
// Purpose: Flip-flop store for the extended register words.
// Assumes: Page one, addresses zero to seven; other addresses read zero.
// Notes:   Writes elsewhere are dropped quietly.
`timescale 1ns/1ns
module gpm_ext_store
  import gpm_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Access from the register bank.
  gpm_ext_if.store ext
);
  logic [15:0] word_r [EXT_DEPTH];
  wire         inRange = ext.addr[8] && (ext.addr[7:3] == 5'h00);
  wire  [2:0]  idx     = ext.addr[2:0];

  ////////////////////////////////////////////////////////////////////////////
  // One register per entry; the skew words come up at mid scale.
  for (genvar i = 0; i < EXT_DEPTH; i++)
  begin : g_word
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
      if (sys_rst)
        word_r[i] <= (i >= EXT_BASE_IDX && i < EXT_BASE_IDX + 3) ? RST_EXT_SKEW : 16'h0000;
      else if (ext.wrEn && inRange && idx == 3'(i))
        word_r[i] <= ext.wrData;
    end
  end

  // Out-of-range reads return zero so software never sees stale words.
  assign ext.rdData = inRange ? word_r[idx] : 16'h0000;
endmodule

//--- rtl/gpm_registers.sv
// Purpose: Management register bank of a triple-speed copper transceiver.
// Assumes: Event and status inputs come from core logic on ref_clk; the
//          half-duplex strap is a pin and is synchronised.
// Notes:   Register port is the decoded management frame: one access per pulse.
`timescale 1ns/1ns
module gpm_registers
  import gpm_pkg::*;
(
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // Management register port.
  input  wire logic [4:0]  regAddr,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  input  wire logic [15:0] regWrData,
  output logic [15:0]      regRdData,
  output logic             regRdValid,
  // Strap pin.
  input  wire logic        gigHalfStrap,
  // Core status levels.
  input  wire logic        resolvedMaster,
  input  wire logic        localRxOk,
  input  wire logic        remoteRxOk,
  input  wire logic        partnerGigFullAbility,
  input  wire logic        partnerGigHalfAbility,
  input  wire logic        gigLinkOk,
  input  wire logic        fastLinkOk,
  input  wire logic        rxIdle,
  input  wire logic        transmitModeIndication,
  // Core event pulses.
  input  wire logic        msConfigFault,
  input  wire logic        idleSymbolError,
  input  wire logic        rxErrorFrame,
  input  wire logic [7:0]  intEvent,
  // Controls to the core.
  output logic             roleForce,
  output logic             roleForceMaster,
  output logic             preferMultiport,
  output logic             advGigFull,
  output logic             advGigHalf,
  output logic             remoteLoopback,
  output logic             ledTestMode,
  output logic             autoCrossOff,
  output logic             straightMode,
  output logic             pcsLoopback,
  output logic             jabberCountEn,
  output logic             cableDiagStart,
  // Interrupt pin.
  output logic             intPin
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage.
  logic [15:8] gigCtl_r;
  logic        msFault_r;
  logic [7:0]  idleCnt_r;
  logic [15:0] extCtl_r;
  logic [15:0] extWrData_r;
  logic [15:0] extRdData_r;
  logic [15:1] loopLed_r;
  logic [15:8] cableDiag_r;
  logic [15:0] rxErrCnt_r;
  logic [7:0]  intEn_r;
  logic [7:0]  intFlag_r;
  logic [15:0] debugCtl_r;
  logic [15:0] phyCtl_r;
  logic [2:0]  strapSync_r;
  logic [1:0]  strapWait_r;
  logic        strapTaken_r;

  gpm_ext_if extBus ();

  gpm_ext_store u_ext_store (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .ext     (extBus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.
  wire wrGig     = regWrEn && (regAddr == OFF_GIG_CTL);
  wire wrExtCtl  = regWrEn && (regAddr == OFF_EXT_CTL);
  wire wrExtData = regWrEn && (regAddr == OFF_EXT_WDATA);
  wire wrLoop    = regWrEn && (regAddr == OFF_LOOP_LED);
  wire wrCable   = regWrEn && (regAddr == OFF_CABLE_DIAG);
  wire wrInt     = regWrEn && (regAddr == OFF_INT_CS);
  wire wrDebug   = regWrEn && (regAddr == OFF_DEBUG_CTL);
  wire wrPhy     = regWrEn && (regAddr == OFF_PHY_CTL);
  wire rdGigStat = regRdEn && (regAddr == OFF_GIG_STAT);
  wire rdRxErr   = regRdEn && (regAddr == OFF_RXERR_CNT);
  wire rdInt     = regRdEn && (regAddr == OFF_INT_CS);

  // Extended access is driven by the write to the control register itself.
  assign extBus.wrEn   = wrExtCtl && regWrData[EC_WRITE];
  assign extBus.addr   = {regWrData[EC_PAGE], regWrData[7:0]};
  assign extBus.wrData = extWrData_r;
  wire   extLoad       = wrExtCtl && !regWrData[EC_WRITE];

  // Counter increments; both hold at all-ones rather than wrap.
  wire       idleInc   = idleSymbolError && rxIdle && transmitModeIndication;
  wire [7:0] idleBase  = rdGigStat ? 8'h00 : idleCnt_r;
  wire [7:0] idleNxt   = (idleInc && idleBase != 8'hff) ? idleBase + 8'h01 : idleBase;
  wire [15:0] rxErrBase = rdRxErr ? 16'h0000 : rxErrCnt_r;
  wire [15:0] rxErrNxt  = (rxErrorFrame && rxErrBase != 16'hffff) ? rxErrBase + 16'h0001 : rxErrBase;

  // Set wins over clear-on-read so no event is lost.
  wire       msFaultNxt = msConfigFault || (msFault_r && !rdGigStat);
  wire [7:0] intFlagNxt = intEvent | (rdInt ? 8'h00 : intFlag_r);

  // Interrupt pin level from enabled flags and polarity.
  wire intActive = |(intFlag_r & intEn_r);
  wire intPinNxt = phyCtl_r[PC_INT_LEVEL] ? intActive : !intActive;

  // Strap is caught once, after the synchroniser has settled.
  wire strapCatch = !strapTaken_r && (strapWait_r == STRAP_SETTLE) &&
                    (strapSync_r[2] == strapSync_r[1]);

  ////////////////////////////////////////////////////////////////////////////
  // Read selection; reserved fields read zero.
  wire [15:0] gigCtlRd  = {gigCtl_r, 8'h00};
  wire [15:0] gigStatRd = {msFault_r, resolvedMaster, localRxOk, remoteRxOk,
                           partnerGigFullAbility, partnerGigHalfAbility, 2'b00,
                           idleCnt_r};
  wire [15:0] pcsRd     = {13'h0000, gigLinkOk, fastLinkOk, 1'b0};
  wire [15:0] rdMux =
    (regAddr == OFF_GIG_CTL)    ? gigCtlRd :
    (regAddr == OFF_GIG_STAT)   ? gigStatRd :
    (regAddr == OFF_EXT_CTL)    ? extCtl_r :
    (regAddr == OFF_EXT_WDATA)  ? extWrData_r :
    (regAddr == OFF_EXT_RDATA)  ? extRdData_r :
    (regAddr == OFF_EXT_STAT)   ? EXT_STAT_VALUE :
    (regAddr == OFF_LOOP_LED)   ? {loopLed_r, 1'b0} :
    (regAddr == OFF_CABLE_DIAG) ? {cableDiag_r, 8'h00} :
    (regAddr == OFF_PCS_LINK)   ? pcsRd :
    (regAddr == OFF_RXERR_CNT)  ? rxErrCnt_r :
    (regAddr == OFF_INT_CS)     ? {intEn_r, intFlag_r} :
    (regAddr == OFF_DEBUG_CTL)  ? debugCtl_r :
    (regAddr == OFF_PHY_CTL)    ? phyCtl_r : 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Read port: data lands one cycle after the strobe.
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      regRdData  <= 16'h0000;
      regRdValid <= 1'b0;
    end
    else
    begin
      regRdData  <= regRdEn ? rdMux : regRdData;
      regRdValid <= regRdEn;
    end
  end

  // Strap synchroniser; only the last two stages are compared.
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      strapSync_r  <= 3'b000;
      strapWait_r  <= 2'd0;
      strapTaken_r <= 1'b0;
    end
    else
    begin
      strapSync_r  <= {strapSync_r[1:0], gigHalfStrap};
      strapWait_r  <= (strapWait_r == STRAP_SETTLE) ? strapWait_r : strapWait_r + 2'd1;
      strapTaken_r <= strapTaken_r || strapCatch || wrGig;
    end
  end

  // Gigabit control; the low byte is never stored.
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      gigCtl_r <= RST_GIG_CTL_HI;
    else if (wrGig)
      gigCtl_r <= regWrData[15:8];
    else if (strapCatch)
      gigCtl_r[GC_ADV_HALF] <= strapSync_r[2];
  end

  // Status latches and counters.
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      msFault_r  <= 1'b0;
      idleCnt_r  <= 8'h00;
      rxErrCnt_r <= 16'h0000;
      intFlag_r  <= 8'h00;
    end
    else
    begin
      msFault_r  <= msFaultNxt;
      idleCnt_r  <= idleNxt;
      rxErrCnt_r <= rxErrNxt;
      intFlag_r  <= intFlagNxt;
    end
  end

  // Extended access registers.
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      extCtl_r    <= 16'h0000;
      extWrData_r <= 16'h0000;
      extRdData_r <= 16'h0000;
    end
    else
    begin
      extCtl_r    <= wrExtCtl ? regWrData : extCtl_r;
      extWrData_r <= wrExtData ? regWrData : extWrData_r;
      extRdData_r <= extLoad ? extBus.rdData : extRdData_r;
    end
  end

  // Vendor control registers.
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      loopLed_r   <= RST_LOOP_LED[15:1];
      cableDiag_r <= 8'h00;
      intEn_r     <= 8'h00;
      debugCtl_r  <= 16'h0000;
      phyCtl_r    <= RST_PHY_CTL;
    end
    else
    begin
      loopLed_r   <= wrLoop ? regWrData[15:1] : loopLed_r;
      // The start bit clears itself one cycle after it is set.
      cableDiag_r <= wrCable ? regWrData[15:8] : {1'b0, cableDiag_r[14:8]};
      intEn_r     <= wrInt ? regWrData[15:8] : intEn_r;
      debugCtl_r  <= wrDebug ? regWrData : debugCtl_r;
      phyCtl_r    <= wrPhy ? (regWrData & PHY_CTL_WMASK) : phyCtl_r;
    end
  end

  // Control outputs, each from a flop, one cycle behind the stored bits.
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      roleForce       <= 1'b0;
      roleForceMaster <= 1'b0;
      preferMultiport <= 1'b0;
      advGigFull      <= 1'b1;
      advGigHalf      <= 1'b0;
      remoteLoopback  <= 1'b0;
      ledTestMode     <= 1'b0;
      autoCrossOff    <= 1'b0;
      straightMode    <= 1'b0;
      pcsLoopback     <= 1'b0;
      jabberCountEn   <= 1'b1;
      cableDiagStart  <= 1'b0;
      intPin          <= 1'b1;
    end
    else
    begin
      roleForce       <= gigCtl_r[GC_MANUAL_EN];
      roleForceMaster <= gigCtl_r[GC_MANUAL_EN] && gigCtl_r[GC_MANUAL_VAL];
      preferMultiport <= !gigCtl_r[GC_MANUAL_EN] && gigCtl_r[GC_PORT_TYPE];
      advGigFull      <= gigCtl_r[GC_ADV_FULL];
      advGigHalf      <= gigCtl_r[GC_ADV_HALF];
      remoteLoopback  <= loopLed_r[LL_REMOTE_LB];
      ledTestMode     <= loopLed_r[LL_LED_TEST];
      autoCrossOff    <= debugCtl_r[DC_SWAP_OFF];
      straightMode    <= debugCtl_r[DC_SWAP_OFF] && debugCtl_r[DC_MDI_SET];
      pcsLoopback     <= debugCtl_r[DC_PCS_LB];
      jabberCountEn   <= phyCtl_r[PC_JAB_EN];
      cableDiagStart  <= cableDiag_r[CD_START];
      intPin          <= intPinNxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_role_force_value: assert property (
    ##1 roleForceMaster == ($past(gigCtl_r[GC_MANUAL_EN]) && $past(gigCtl_r[GC_MANUAL_VAL])))
    else $error("Forced role does not follow override bits.");

  a_port_type_gate: assert property (
    gigCtl_r[GC_MANUAL_EN] |=> !preferMultiport)
    else $error("Port type preference leaked under override.");

  a_fault_latch_read: assert property (
    msConfigFault |=> msFault_r)
    else $error("Configuration fault flag did not latch.");

  a_fault_read_clear: assert property (
    (rdGigStat && !msConfigFault) |=> !msFault_r)
    else $error("Configuration fault flag survived a read.");

  a_idle_count_step: assert property (
    (idleInc && !rdGigStat && idleCnt_r != 8'hff) |=> idleCnt_r == $past(idleCnt_r) + 8'h01)
    else $error("Idle error counter did not advance.");

  // Words outside the implemented page must come back as zero.
  a_ext_read_load: assert property (
    extLoad |=> extRdData_r == ($past(extBus.addr[8] && extBus.addr[7:3] == 5'h00) ?
                                $past(extBus.rdData) : 16'h0000))
    else $error("Extended read data not loaded.");

  a_ext_write_back: assert property (
    (extBus.wrEn && extBus.addr[8] && extBus.addr[7:3] == 5'h00) ##1 !extBus.wrEn ##1
    (extLoad && extBus.addr == $past(extBus.addr, 2)) |=> extRdData_r == $past(extWrData_r, 3))
    else $error("Extended write did not reach the store.");

  a_rxerr_read_clear: assert property (
    (rdRxErr && !rxErrorFrame) |=> rxErrCnt_r == 16'h0000)
    else $error("Receive error counter not cleared by read.");

  a_flag_set_wins: assert property (
    (rdInt && intEvent != 8'h00) |=> (intFlag_r & $past(intEvent)) == $past(intEvent))
    else $error("Event lost on flag clear.");

  a_int_pin_level: assert property (
    (intFlag_r & intEn_r) != 8'h00 ##1 1 |-> intPin == $past(phyCtl_r[PC_INT_LEVEL]))
    else $error("Interrupt pin not asserted at programmed polarity.");

  a_cross_straight: assert property (
    !debugCtl_r[DC_SWAP_OFF] |=> !straightMode && !autoCrossOff)
    else $error("Straight select acted with auto crossover on.");
endmodule

//--- tb/gpm_mgmt_host.sv
// Purpose: Station management controller model for the register port.
// Assumes: One access per call; a read answers on its take edge, one cycle after launch.
// Notes:   Requests launch just after a rising edge by non-blocking assignment.
`timescale 1ns/1ns
module gpm_mgmt_host
  import gpm_pkg::*;
(
  // Clock.
  input  wire logic        ref_clk,
  // Register port.
  output logic [4:0]       regAddr,
  output logic             regWrEn,
  output logic             regRdEn,
  output logic [15:0]      regWrData,
  input  wire logic [15:0] regRdData,
  input  wire logic        regRdValid
);
  ////////////////////////////////////////////////////////////////////////
  // Port idles from time zero.
  initial
  begin
    regAddr   = 5'h00;
    regWrEn   = 1'b0;
    regRdEn   = 1'b0;
    regWrData = 16'h0000;
  end

  // One write; data is inverted afterwards so nothing relies on a stale word.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regAddr   <= a;
    regWrEn   <= 1'b1;
    regWrData <= (a == OFF_GIG_CTL) ? {d[15:8], 8'h00} : d;
    @(posedge ref_clk);
    regWrEn   <= 1'b0;
    regWrData <= ~regWrData;
  endtask

  // One read with a bounded wait for the valid pulse.
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    int n;
    @(posedge ref_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge ref_clk);
    regRdEn <= 1'b0;
    #1;
    for (n = 0; n < 4 && regRdValid !== 1'b1; n++)
    begin
      @(posedge ref_clk);
      #1;
    end
    d = (regRdValid === 1'b1) ? regRdData : 16'hxxxx;
  endtask
endmodule

//--- tb/tb_gpm_registers.sv
// Purpose: Self-checking bench for the management register bank.
// Assumes: Strap pin high at the first reset and low at the second one.
// Notes:   Status levels and event pulses are packed vectors driven here.
`timescale 1ns/1ns
module tb_gpm_registers
  import gpm_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        strapPin = 1'b1;
  logic [8:0]  lv      = 9'h000;
  logic [10:0] ev      = 11'h000;
  logic [4:0]  regAddr;
  logic        regWrEn, regRdEn, regRdValid;
  logic [15:0] regWrData, regRdData, d;
  logic        roleForce, roleForceMaster, preferMultiport, advGigFull, advGigHalf;
  logic        remoteLoopback, ledTestMode, autoCrossOff, straightMode, pcsLoopback;
  logic        jabberCountEn, intPin, cableDiagStart;
  int          badCount, samplesChecked, cycles, i;
  logic [15:0] dv [3] = '{16'h00c1, 16'h0040, 16'h0080};
  logic [7:0]  f;

  ////////////////////////////////////////////////////////////////////////
  // Clock and cycle ceiling; the run needs well under a thousand cycles.
  initial
  begin
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      badCount++;
      stop_test;
    end
  end

  gpm_mgmt_host gpm_mgmt_host_i (.ref_clk(ref_clk), .regAddr(regAddr), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid));

  gpm_registers gpm_registers_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData),
    .regRdValid(regRdValid), .gigHalfStrap(strapPin), .resolvedMaster(lv[8]), .localRxOk(lv[7]),
    .remoteRxOk(lv[6]), .partnerGigFullAbility(lv[5]), .partnerGigHalfAbility(lv[4]),
    .gigLinkOk(lv[3]), .fastLinkOk(lv[2]), .rxIdle(lv[1]), .transmitModeIndication(lv[0]),
    .msConfigFault(ev[10]), .idleSymbolError(ev[9]), .rxErrorFrame(ev[8]), .intEvent(ev[7:0]),
    .roleForce(roleForce), .roleForceMaster(roleForceMaster), .preferMultiport(preferMultiport),
    .advGigFull(advGigFull), .advGigHalf(advGigHalf), .remoteLoopback(remoteLoopback),
    .ledTestMode(ledTestMode), .autoCrossOff(autoCrossOff), .straightMode(straightMode),
    .pcsLoopback(pcsLoopback), .jabberCountEn(jabberCountEn), .cableDiagStart(cableDiagStart),
    .intPin(intPin));

  ////////////////////////////////////////////////////////////////////////
  // Compare, read-and-compare, event pulse and output settle helpers.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      badCount++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [15:0] exp);
    gpm_mgmt_host_i.rd(a, d);
    chk(d, exp);
  endtask
  task automatic fire(input logic [10:0] v);
    @(posedge ref_clk);
    ev <= v;
    @(posedge ref_clk);
    ev <= 11'h000;
  endtask
  task automatic settle;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  task automatic stop_test;
    $display("checked %0d mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
    chk(16'(advGigFull), 16'h0001);
    chk(16'(advGigHalf), 16'h0001);
    chk(16'(intPin), 16'h0001);
    chk(16'(jabberCountEn), 16'h0001);
    rdchk(OFF_GIG_CTL, 16'h0300);
    rdchk(OFF_PHY_CTL, 16'h0200);
    gpm_mgmt_host_i.rd(OFF_EXT_STAT, d);
    chk(d & 16'hf000, 16'h3000);
    rdchk(5'h0e, 16'h0000);
    // Every combination of override, role value and port type.
    for (i = 0; i < 8; i++)
    begin
      gpm_mgmt_host_i.wr(OFF_GIG_CTL, {3'b000, i[2:0], 10'h300});
      settle;
      chk(16'(roleForce), 16'(i[2]));
      if (i[2])
        chk(16'(roleForceMaster), 16'(i[1]));
      else
        chk(16'(preferMultiport), 16'(i[0]));
    end
    gpm_mgmt_host_i.wr(OFF_GIG_CTL, 16'h0000);
    settle;
    chk({14'h0000, advGigFull, advGigHalf}, 16'h0000);
    // Status levels, idle errors outside idle or send mode, then clear-on-read.
    @(posedge ref_clk);
    lv <= 9'b1_0110_1011;
    repeat (3) fire(11'h300);
    @(posedge ref_clk);
    lv[1:0] <= 2'b01;
    fire(11'h200);
    lv[1:0] <= 2'b10;
    fire(11'h200);
    lv[1:0] <= 2'b11;
    fire(11'h400);
    gpm_mgmt_host_i.wr(OFF_GIG_STAT, 16'h0000);
    rdchk(OFF_GIG_STAT, 16'hd803);
    rdchk(OFF_GIG_STAT, 16'h5800);
    rdchk(OFF_PCS_LINK, 16'h0004);
    rdchk(OFF_RXERR_CNT, 16'h0003);
    rdchk(OFF_RXERR_CNT, 16'h0000);
    // Extended write, page zero write dropped, read back, skew default.
    gpm_mgmt_host_i.wr(OFF_EXT_WDATA, 16'ha5c3);
    gpm_mgmt_host_i.wr(OFF_EXT_CTL, 16'h8102);
    gpm_mgmt_host_i.wr(OFF_EXT_WDATA, 16'h1111);
    gpm_mgmt_host_i.wr(OFF_EXT_CTL, 16'h8002);
    gpm_mgmt_host_i.wr(OFF_EXT_CTL, 16'h0102);
    rdchk(OFF_EXT_RDATA, 16'ha5c3);
    rdchk(OFF_EXT_CTL, 16'h0102);
    gpm_mgmt_host_i.wr(OFF_EXT_CTL, 16'h0104);
    rdchk(OFF_EXT_RDATA, 16'h7777);
    gpm_mgmt_host_i.wr(OFF_EXT_WDATA, 16'h5a3c);
    gpm_mgmt_host_i.wr(OFF_EXT_CTL, 16'h8105);
    gpm_mgmt_host_i.wr(OFF_EXT_CTL, 16'h0105);
    rdchk(OFF_EXT_RDATA, 16'h5a3c);
    gpm_mgmt_host_i.wr(OFF_EXT_CTL, 16'h0002);
    rdchk(OFF_EXT_RDATA, 16'h0000);
    // Loopback and LED test on, then off.
    gpm_mgmt_host_i.wr(OFF_LOOP_LED, 16'h03f8);
    settle;
    chk({14'h0000, remoteLoopback, ledTestMode}, 16'h0003);
    gpm_mgmt_host_i.wr(OFF_LOOP_LED, 16'h02f0);
    settle;
    chk({14'h0000, remoteLoopback, ledTestMode}, 16'h0000);
    // Diagnostic start bit pulses once and clears itself; the low byte is read-only.
    gpm_mgmt_host_i.wr(OFF_CABLE_DIAG, 16'hc5ff);
    @(posedge ref_clk);
    #1;
    chk(16'(cableDiagStart), 16'h0001);
    @(posedge ref_clk);
    #1;
    chk(16'(cableDiagStart), 16'h0000);
    rdchk(OFF_CABLE_DIAG, 16'h4500);
    // Crossover override and low-speed loopback settings.
    for (i = 0; i < 3; i++)
    begin
      gpm_mgmt_host_i.wr(OFF_DEBUG_CTL, dv[i]);
      settle;
      chk({14'h0000, autoCrossOff, pcsLoopback}, {14'h0000, dv[i][6], dv[i][0]});
      chk(16'(straightMode), 16'(dv[i][7] && dv[i][6]));
    end
    // Each source enabled alone, with a masked neighbour firing too.
    for (i = 0; i < 8; i++)
    begin
      f = 8'(1 << i) | 8'(1 << ((i + 1) % 8));
      gpm_mgmt_host_i.wr(OFF_INT_CS, 16'h0100 << i);
      fire({3'b000, f});
      settle;
      chk(16'(intPin), 16'h0000);
      rdchk(OFF_INT_CS, (16'h0100 << i) | {8'h00, f});
      settle;
      chk(16'(intPin), 16'h0001);
    end
    // All sources masked: flags latch but the pin stays idle.
    gpm_mgmt_host_i.wr(OFF_INT_CS, 16'h0000);
    fire(11'h0ff);
    settle;
    chk(16'(intPin), 16'h0001);
    rdchk(OFF_INT_CS, 16'h00ff);
    // An event in the very cycle of the clearing read must survive it.
    fork
      fire(11'h001);
      rdchk(OFF_INT_CS, 16'h0000);
    join
    rdchk(OFF_INT_CS, 16'h0001);
    // Pin polarity high with nothing pending; jabber counting off.
    gpm_mgmt_host_i.wr(OFF_PHY_CTL, 16'h4000);
    settle;
    chk({14'h0000, intPin, jabberCountEn}, 16'h0000);
    // An enabled jabber event drives the pin high at this polarity.
    gpm_mgmt_host_i.wr(OFF_INT_CS, 16'h8000);
    fire(11'h080);
    settle;
    chk(16'(intPin), 16'h0001);
    // Second reset with the strap low: defaults return, half-duplex starts clear.
    @(posedge ref_clk);
    sys_rst  <= 1'b1;
    strapPin <= 1'b0;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
    chk({13'h0000, advGigHalf, intPin, jabberCountEn}, 16'h0003);
    rdchk(OFF_GIG_CTL, 16'h0200);
    rdchk(OFF_INT_CS, 16'h0000);
    stop_test;
  end
endmodule
